/* File: gpbp_defines.vh */
// Register offsets, field positions and reset values for the port unit
`ifndef GPBP_DEFINES_VH
`define GPBP_DEFINES_VH

// Byte addresses are four times the printed register index
`define GPBP_IDX_SIX_DATA       8'h00
`define GPBP_IDX_BYTE_DATA      8'h01
`define GPBP_IDX_SIX_DIR        8'h04
`define GPBP_IDX_BYTE_DIR       8'h05
`define GPBP_IDX_SIX_PUE        8'h0B
`define GPBP_IDX_BYTE_PUE       8'h0C
`define GPBP_IDX_OSC_MODE       8'h10

`define GPBP_OSC_SEL_BIT        7
`define GPBP_SIX_BIT_TWO        2
`define GPBP_SIX_BIT_FOUR       4

`define GPBP_DIR_RESET          8'h00
`define GPBP_PUE_RESET          8'h00
`define GPBP_SIX_DIR_RESET      6'h00
`define GPBP_SIX_PUE_RESET      6'h00
`define GPBP_OSC_MODE_RESET     1'b0

`endif

/* File: gpbp_pin_sync.v */
// Two-stage synchroniser for a bank of pin inputs
`timescale 1ns/1ps
`default_nettype none

module gpbp_pin_sync #(
	parameter WIDTH = 8
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_sync
);

	reg [WIDTH-1:0] stage_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_q  <= {WIDTH{1'b0}};
			pin_sync <= {WIDTH{1'b0}};
		end else begin
			stage_q  <= pin_in;
			pin_sync <= stage_q;
		end
	end

endmodule // gpbp_pin_sync

`default_nettype wire

/* File: gpbp_port.v */
// Six-pin port pullups and full byte port with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "gpbp_defines.vh"

module gpbp_port (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        osc_internal_mode,
	input  wire        quad_bus_rate_clock,
	input  wire [5:0]  six_pin_in,
	output reg  [5:0]  six_pin_out,
	output reg  [5:0]  six_pin_oe,
	output reg  [5:0]  six_pin_pullup,
	input  wire [7:0]  byte_pin_in,
	output reg  [7:0]  byte_pin_out,
	output reg  [7:0]  byte_pin_oe,
	output reg  [7:0]  byte_pin_pullup,
	output reg         second_oscillator_pin_out,
	output reg         second_oscillator_pin_oe
);

	// ****************************************
	// Registers and synchronised pins
	// ****************************************
	reg  [5:0] six_pin_data_latch_q;
	reg  [5:0] six_pin_direction_q;
	reg  [5:0] six_pin_pullup_enable_q;
	reg        osc_pin_clock_out_select_q;
	reg  [7:0] byte_port_data_latch_q;
	reg  [7:0] byte_port_direction_q;
	reg  [7:0] byte_port_pullup_enable_q;
	wire [5:0] six_sync;
	wire [7:0] byte_sync;

	gpbp_pin_sync #(.WIDTH(6)) u_six_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   (six_pin_in),
		.pin_sync (six_sync)
	);

	gpbp_pin_sync #(.WIDTH(8)) u_byte_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   (byte_pin_in),
		.pin_sync (byte_sync)
	);

	// ****************************************
	// Address decode
	// ****************************************
	function hit;
		input [11:0] addr;
		input [7:0]  idx;
		begin
			hit = (addr == {2'b00, idx, 2'b00});
		end
	endfunction

	// Per-bit choice of latch or pin level on a data read
	function [7:0] read_merge;
		input [7:0] dir;
		input [7:0] latch;
		input [7:0] pins;
		begin
			read_merge = (dir & latch) | (~dir & pins);
		end
	endfunction

	// Pullup only on pins whose direction bit selects input
	function [7:0] pull_gate;
		input [7:0] enable;
		input [7:0] dir;
		begin
			pull_gate = enable & ~dir;
		end
	endfunction

	wire setup   = psel && !penable;
	wire wr_acc  = psel && penable && pwrite;
	wire a_sdat  = hit(paddr, `GPBP_IDX_SIX_DATA);
	wire a_bdat  = hit(paddr, `GPBP_IDX_BYTE_DATA);
	wire a_sdir  = hit(paddr, `GPBP_IDX_SIX_DIR);
	wire a_bdir  = hit(paddr, `GPBP_IDX_BYTE_DIR);
	wire a_spue  = hit(paddr, `GPBP_IDX_SIX_PUE);
	wire a_bpue  = hit(paddr, `GPBP_IDX_BYTE_PUE);
	wire mapped  = a_sdat | a_bdat | a_sdir | a_bdir | a_spue | a_bpue;

	// ****************************************
	// Write strobes at the end of the access cycle
	// ****************************************
	wire commit  = wr_acc && pready;
	wire wr_sdat = commit && a_sdat;
	wire wr_bdat = commit && a_bdat;
	wire wr_sdir = commit && a_sdir;
	wire wr_bdir = commit && a_bdir;
	wire wr_spue = commit && a_spue;
	wire wr_bpue = commit && a_bpue;

	// Second pin acts as clock output only in internal/RC mode
	// clock out select
	wire osc_clk_sel = osc_internal_mode && osc_pin_clock_out_select_q;

	// ****************************************
	// Read mux
	// ****************************************
	reg  [7:0] rd_d;
	wire [7:0] six_rd_merge;
	wire [7:0] byte_rd_merge;

	assign six_rd_merge = read_merge({2'b00, six_pin_direction_q},
		{2'b00, six_pin_data_latch_q}, {2'b00, six_sync});
	assign byte_rd_merge = read_merge(byte_port_direction_q,
		byte_port_data_latch_q, byte_sync);

	always @* begin
		rd_d = 8'h00;
		if (a_sdat)
			rd_d = six_rd_merge;
		if (a_bdat)
			rd_d = byte_rd_merge;
		if (a_sdir)
			rd_d = {2'b00, six_pin_direction_q};
		if (a_bdir)
			rd_d = byte_port_direction_q;
		if (a_spue)
			rd_d = {osc_pin_clock_out_select_q, 1'b0, six_pin_pullup_enable_q};
		if (a_bpue)
			rd_d = byte_port_pullup_enable_q;
	end

	// ****************************************
	// APB slave, answers in the access cycle
	// ****************************************
	// ready in first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Error answer for unmapped offsets
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup && !mapped;
		end
	end

	// Read data stands only with its ready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= {24'h00_0000, rd_d};
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Control registers, cleared by reset
	// ****************************************
	// six-pin direction cleared
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			six_pin_direction_q <= `GPBP_SIX_DIR_RESET;
		end else if (wr_sdir) begin
			six_pin_direction_q <= pwdata[5:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_port_direction_q <= `GPBP_DIR_RESET;
		end else if (wr_bdir) begin
			byte_port_direction_q <= pwdata[7:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			six_pin_pullup_enable_q    <= `GPBP_SIX_PUE_RESET;
			osc_pin_clock_out_select_q <= `GPBP_OSC_MODE_RESET;
		end else if (wr_spue) begin
			six_pin_pullup_enable_q    <= pwdata[5:0];
			osc_pin_clock_out_select_q <= pwdata[`GPBP_OSC_SEL_BIT];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_port_pullup_enable_q <= `GPBP_PUE_RESET;
		end else if (wr_bpue) begin
			byte_port_pullup_enable_q <= pwdata[7:0];
		end
	end

	// ****************************************
	// Data latches, untouched by reset
	// ****************************************
	// six-pin latch always writable
	always @(posedge pclk) begin
		if (wr_sdat) begin
			six_pin_data_latch_q <= pwdata[5:0];
		end
	end

	always @(posedge pclk) begin
		if (wr_bdat) begin
			byte_port_data_latch_q <= pwdata[7:0];
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	reg  [5:0] six_oe_d;
	reg  [5:0] six_pu_d;
	wire [7:0] six_pu_full;
	wire [7:0] byte_pu_d;

	assign six_pu_full = pull_gate({2'b00, six_pin_pullup_enable_q},
		{2'b00, six_pin_direction_q});
	assign byte_pu_d = pull_gate(byte_port_pullup_enable_q, byte_port_direction_q);

	always @* begin
		six_oe_d = six_pin_direction_q;
		six_pu_d = six_pu_full[5:0];
		six_oe_d[`GPBP_SIX_BIT_TWO] = 1'b0;
		if (osc_clk_sel) begin
			six_oe_d[`GPBP_SIX_BIT_FOUR] = 1'b0;
			six_pu_d[`GPBP_SIX_BIT_FOUR] = 1'b0;
		end
	end

	// Six-pin outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			six_pin_out    <= 6'h00;
			six_pin_oe     <= 6'h00;
			six_pin_pullup <= 6'h00;
		end else begin
			six_pin_out    <= six_pin_data_latch_q;
			six_pin_oe     <= six_oe_d;
			six_pin_pullup <= six_pu_d;
		end
	end

	// Byte port outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_pin_out    <= 8'h00;
			byte_pin_oe     <= 8'h00;
			byte_pin_pullup <= 8'h00;
		end else begin
			byte_pin_out    <= byte_port_data_latch_q;
			byte_pin_oe     <= byte_port_direction_q;
			byte_pin_pullup <= byte_pu_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_oscillator_pin_out <= 1'b0;
			second_oscillator_pin_oe  <= 1'b0;
		end else begin
			second_oscillator_pin_out <= osc_clk_sel & quad_bus_rate_clock;
			second_oscillator_pin_oe  <= osc_clk_sel;
		end
	end

endmodule // gpbp_port

`default_nettype wire

/* File: gpbp_port_asserts.sv */
// Checker for the port unit pins and bus answers
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module gpbp_port_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        osc_internal_mode,
	input wire logic        quad_bus_rate_clock,
	input wire logic [5:0]  six_pin_oe,
	input wire logic [5:0]  six_pin_pullup,
	input wire logic [7:0]  byte_pin_out,
	input wire logic [7:0]  byte_pin_oe,
	input wire logic [7:0]  byte_pin_pullup,
	input wire logic        second_oscillator_pin_out,
	input wire logic        second_oscillator_pin_oe
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
AST_ANSWER: assert property (psel && !penable |=> pready) else $error("no answer");
AST_B_PU: assert property ((byte_pin_pullup & byte_pin_oe) == 8'h00) else $error("pu");
AST_S_PU: assert property ((six_pin_pullup & six_pin_oe) == 6'h00) else $error("pu6");
AST_BIT2: assert property (!six_pin_oe[2]) else $error("bit two drives");
AST_XTAL: assert property (!osc_internal_mode [*2] |=> !second_oscillator_pin_oe)
	else $error("osc pin driven");
AST_CLK: assert property (second_oscillator_pin_oe |->
	second_oscillator_pin_out == $past(quad_bus_rate_clock)) else $error("clk out");
AST_B_DIR: assert property (pready && pwrite && paddr == 12'h014 |=> ##1
	byte_pin_oe == $past(pwdata[7:0], 2)) else $error("dir");
AST_B_RD: assert property (pready && !pwrite && paddr == 12'h004 |->
	(prdata[7:0] & byte_pin_oe) == (byte_pin_out & byte_pin_oe)) else $error("rd");
endmodule // gpbp_port_asserts
bind gpbp_port gpbp_port_asserts u_gpbp_port_asserts (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .osc_internal_mode, .quad_bus_rate_clock,
	.six_pin_oe, .six_pin_pullup, .byte_pin_out, .byte_pin_oe, .byte_pin_pullup,
	.second_oscillator_pin_out, .second_oscillator_pin_oe);
`default_nettype wire

/* File: gpbp_pin_model.sv */
// Board pins: external drive, pullups, floating lines
`timescale 1ns/1ps
`default_nettype none
// ****
// Pin model
// ****
module gpbp_pin_model (
	input wire logic       pclk,
	input wire logic       ext_en,
	input wire logic [7:0] ext,
	input wire logic [7:0] byte_pin_out,
	input wire logic [7:0] byte_pin_oe,
	input wire logic [7:0] byte_pin_pullup,
	output logic [7:0]     byte_pin_in,
	input wire logic [5:0] six_pin_out,
	input wire logic [5:0] six_pin_oe,
	input wire logic [5:0] six_pin_pullup,
	output logic [5:0]     six_pin_in
);
logic flt = 1'b0;
// Undriven line without pullup wanders
always @(posedge pclk) flt <= ~flt;
assign byte_pin_in = byte_pin_oe & byte_pin_out |
	~byte_pin_oe & (ext_en ? ext : byte_pin_pullup | {8{flt}});
assign six_pin_in = six_pin_oe & six_pin_out |
	~six_pin_oe & (ext_en ? ext[5:0] : six_pin_pullup | {6{flt}});
endmodule // gpbp_pin_model
`default_nettype wire

/* File: gpbp_tb.sv */
// Testbench for the port unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("ERROR %0t mismatch", $time); end end
// ****
// Testbench
// ****
module testbench;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
logic osc_internal_mode = 0, quad_bus_rate_clock = 0, ext_en = 1;
logic second_oscillator_pin_out, second_oscillator_pin_oe;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, rd;
logic err;
logic [7:0] ext = 8'h3C, byte_pin_in, byte_pin_out, byte_pin_oe, byte_pin_pullup;
logic [5:0] six_pin_in, six_pin_out, six_pin_oe, six_pin_pullup;
int fails = 0, compares = 0;
always #20 pclk = ~pclk;
always @(posedge pclk) quad_bus_rate_clock <= ~quad_bus_rate_clock;
gpbp_port u_gpbp_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .osc_internal_mode, .quad_bus_rate_clock, .six_pin_in,
	.six_pin_out, .six_pin_oe, .six_pin_pullup, .byte_pin_in, .byte_pin_out,
	.byte_pin_oe, .byte_pin_pullup, .second_oscillator_pin_out, .second_oscillator_pin_oe);
gpbp_pin_model u_gpbp_pin_model (.pclk, .ext_en, .ext, .byte_pin_out, .byte_pin_oe,
	.byte_pin_pullup, .byte_pin_in, .six_pin_out, .six_pin_oe, .six_pin_pullup, .six_pin_in);
task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
	int n;
	n = 0;
	@(posedge pclk);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= {24'h0, d};
	@(posedge pclk);
	penable <= 1;
	do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
	if (pready !== 1'b1) begin fails++; print_verdict; end
	rd = prdata;
	err = pslverr;
	psel <= 0;
	penable <= 0;
	repeat (4) @(posedge pclk);
endtask
task t_reg;
	apb(0, 12'h010, 0); `CHK(rd, 32'h0)
	apb(0, 12'h014, 0); `CHK(rd, 32'h0)
	apb(0, 12'h02C, 0); `CHK(rd, 32'h0)
	apb(0, 12'h030, 0); `CHK(rd, 32'h0)
	apb(0, 12'h008, 0); `CHK({err, rd}, 33'h100000000)
	$display("t_reg done");
endtask
task t_byte;
	apb(1, 12'h004, 8'hA5);
	apb(0, 12'h004, 0); `CHK(rd, 32'h3C)
	apb(1, 12'h014, 8'hF0);
	apb(0, 12'h004, 0); `CHK(rd, 32'hAC)
	`CHK({byte_pin_oe, byte_pin_out[7:4]}, 12'hF0A)
	$display("t_byte done");
endtask
task t_pull;
	ext_en <= 0;
	apb(1, 12'h030, 8'hFF);
	apb(0, 12'h004, 0); `CHK(rd, 32'hAF)
	`CHK(byte_pin_pullup, 8'h0F)
	apb(1, 12'h014, 8'h00); `CHK(byte_pin_pullup, 8'hFF)
	apb(1, 12'h030, 8'h00); `CHK(byte_pin_pullup, 8'h00)
	ext_en <= 1;
	$display("t_pull done");
endtask
task t_rst;
	apb(1, 12'h014, 8'hFF);
	presetn <= 0;
	repeat (2) @(posedge pclk);
	presetn <= 1;
	`CHK(byte_pin_oe, 8'h00)
	apb(0, 12'h014, 0); `CHK(rd, 32'h0)
	apb(1, 12'h014, 8'hFF);
	apb(0, 12'h004, 0); `CHK(rd, 32'hA5)
	`CHK(byte_pin_out, 8'hA5)
	$display("t_rst done");
endtask
task t_six;
	apb(1, 12'h02C, 8'h3F);
	apb(1, 12'h000, 8'h15);
	apb(1, 12'h010, 8'h3F); `CHK({six_pin_oe, six_pin_pullup}, 12'hEC0)
	apb(0, 12'h000, 0); `CHK(rd, 32'h15)
	`CHK(six_pin_out, 6'h15)
	apb(1, 12'h010, 8'h00); `CHK(six_pin_pullup, 6'h3F)
	apb(0, 12'h000, 0); `CHK(rd, 32'h3C)
	apb(1, 12'h02C, 8'h80);
	apb(1, 12'h010, 8'h3F);
	osc_internal_mode <= 1;
	repeat (3) @(posedge pclk);
	`CHK({second_oscillator_pin_oe, six_pin_oe[4]}, 2'b10)
	osc_internal_mode <= 0;
	repeat (3) @(posedge pclk);
	`CHK({second_oscillator_pin_oe, six_pin_oe[4]}, 2'b01)
	$display("t_six done");
endtask
task print_verdict;
	$display("compares %0d fails %0d", compares, fails);
	if (fails == 0 && compares > 0) $display("Test passed");
	else $display("Test failed");
	$finish;
endtask
initial begin
	repeat (16) @(posedge pclk);
	presetn <= 1;
	t_reg;
	t_byte;
	t_pull;
	t_rst;
	t_six;
	print_verdict;
end
endmodule // testbench
`default_nettype wire
